/* hw/pmx_phy_regs.vh */
// register offsets, field positions, reset values and timing for the phy mode/crossover registers
// assumes inclusion by design files only; definitions only
`ifndef PMX_PHY_REGS_VH
`define PMX_PHY_REGS_VH

`define PMX_ADDR_ENERGY_CTL 5'h11
`define PMX_ADDR_MODE_ADDR 5'h12
`define PMX_ADDR_XOVER_CTL 5'h1b

`define PMX_EDPD_BIT 13
`define PMX_ENERGY_BIT 1
`define PMX_MODE_HI 7
`define PMX_MODE_LO 5
`define PMX_PHY_ADDRESS_FIELD_HI 4
`define PMX_PHY_ADDRESS_FIELD_LO 0
`define PMX_XOVR_OVERRIDE_BIT 15
`define PMX_XOVR_AUTO_BIT 14
`define PMX_XOVR_STATE_BIT 13
`define PMX_PLL_FORCE_BIT 10
`define PMX_POL_BIT 4
`define PMX_SCRATCH_HI 3

`define PMX_MODE_RST 3'h7
`define PMX_PHY_ADDRESS_FIELD_RST 5'h01
`define PMX_RSVD_RD 4'h0

`define PMX_MODE_10HD 3'h0
`define PMX_MODE_10FD 3'h1
`define PMX_MODE_100HD 3'h2
`define PMX_MODE_100FD 3'h3
`define PMX_MODE_AN100HD 3'h4
`define PMX_MODE_REPEATER 3'h5
`define PMX_MODE_ALL 3'h7

`define PMX_ENERGY_WINDOW_MS 256
`define PMX_CLK_KHZ 20000

`endif

/* hw/pmx_energy_timer.v */
// energy-on window timer: counts a long idle window while no line energy is seen
// assumes energy_seen_i is synchronous; the window length is a parameter so sims can shorten it
module pmx_energy_timer #(
    parameter WINDOW_CYCLES = 5120000,
    parameter CW = 23
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire energy_seen_i,
    output reg expired_o
);
    reg [CW-1:0] count_r;

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_r <= {CW{1'b0}};
            expired_o <= 1'b0;
        end else if (energy_seen_i) begin
            count_r <= {CW{1'b0}};
            expired_o <= 1'b0;
        end else if (count_r == WINDOW_CYCLES[CW-1:0] - 1'b1) begin
            // hold at the end so the pulse lasts while idle persists
            expired_o <= 1'b1;
        end else begin
            count_r <= count_r + 1'b1;
            expired_o <= 1'b0;
        end
    end
endmodule

/* hw/pmx_mode_xover_regs.v */
// phy vendor registers: energy-detect power-down, operating mode / address, crossover control
// assumes a management serial frame decoder outside presents one-cycle read/write strobes
// with a 5-bit phy address and 5-bit register address; all inputs synchronous to clock_i
`include "pmx_phy_regs.vh"

module pmx_mode_xover_regs #(
    parameter WINDOW_CYCLES = `PMX_ENERGY_WINDOW_MS * `PMX_CLK_KHZ
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire soft_rst_i,
    input wire mgmt_wr_i,
    input wire mgmt_rd_i,
    input wire [4:0] mgmt_phy_addr_i,
    input wire [4:0] mgmt_reg_addr_i,
    input wire [15:0] mgmt_wdata_i,
    input wire line_energy_i,
    input wire polarity_reversed_i,
    input wire crossover_auto_strap_i,
    input wire neg_speed100_i,
    input wire neg_full_duplex_i,
    output reg [15:0] mgmt_rdata_o,
    output reg mgmt_rvalid_o,
    output reg mgmt_addr_hit_o,
    output reg energy_detect_powerdown_en_o,
    output reg line_energy_present_o,
    output reg [2:0] op_mode_o,
    output reg [4:0] phy_address_field_o,
    output reg speed100_o,
    output reg full_duplex_o,
    output reg autoneg_en_o,
    output reg [3:0] advert_abilities_o,
    output reg crs_on_tx_o,
    output reg crossover_auto_en_o,
    output reg pairs_swapped_o,
    output reg rx_pll_ref_lock_force_o,
    output reg tenbase_polarity_reversed_o
);
    reg edpd_r;
    reg energy_r;
    reg [2:0] mode_r;
    reg [4:0] phy_address_field_r;
    reg xovr_override_r;
    reg xovr_auto_r;
    reg xovr_state_r;
    reg pll_force_r;

    wire expired;
    wire addr_match;
    wire wr_hit;

    // phy address must match before any access is honoured
    assign addr_match = (mgmt_phy_addr_i == phy_address_field_r);
    assign wr_hit = mgmt_wr_i & addr_match;

    pmx_energy_timer #(
        .WINDOW_CYCLES(WINDOW_CYCLES),
        .CW(32)
    ) u_energy_timer (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .energy_seen_i(line_energy_i),
        .expired_o(expired)
    );

    // software-reset domain: only edpd and crossover (non-retained) fields return to default
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            edpd_r <= 1'b0;
            xovr_override_r <= 1'b0;
            xovr_auto_r <= 1'b0;
            xovr_state_r <= 1'b0;
        end else if (soft_rst_i) begin
            edpd_r <= 1'b0;
            xovr_override_r <= 1'b0;
            xovr_auto_r <= 1'b0;
            xovr_state_r <= 1'b0;
        end else begin
            if (wr_hit && mgmt_reg_addr_i == `PMX_ADDR_ENERGY_CTL) begin
                // reserved bits are not stored; they read back as zero
                edpd_r <= mgmt_wdata_i[`PMX_EDPD_BIT];
            end else if (wr_hit && mgmt_reg_addr_i == `PMX_ADDR_XOVER_CTL) begin
                xovr_override_r <= mgmt_wdata_i[`PMX_XOVR_OVERRIDE_BIT];
                xovr_auto_r <= mgmt_wdata_i[`PMX_XOVR_AUTO_BIT];
                xovr_state_r <= mgmt_wdata_i[`PMX_XOVR_STATE_BIT];
            end
        end
    end

    // retained fields: only the hardware reset touches them
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_r <= `PMX_MODE_RST;
            phy_address_field_r <= `PMX_PHY_ADDRESS_FIELD_RST;
            pll_force_r <= 1'b0;
            energy_r <= 1'b1;
        end else begin
            if (wr_hit && mgmt_reg_addr_i == `PMX_ADDR_MODE_ADDR) begin
                mode_r <= mgmt_wdata_i[`PMX_MODE_HI:`PMX_MODE_LO];
                phy_address_field_r <= mgmt_wdata_i[`PMX_PHY_ADDRESS_FIELD_HI:`PMX_PHY_ADDRESS_FIELD_LO];
            end
            if (wr_hit && mgmt_reg_addr_i == `PMX_ADDR_XOVER_CTL) begin
                pll_force_r <= mgmt_wdata_i[`PMX_PLL_FORCE_BIT];
            end
            // energy flag ignores software reset; fresh energy wins over the idle timeout
            if (line_energy_i) begin
                energy_r <= 1'b1;
            end else if (expired) begin
                energy_r <= 1'b0;
            end
        end
    end

    // register read-back and derived mode outputs
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mgmt_rdata_o <= 16'h0000;
            mgmt_rvalid_o <= 1'b0;
            mgmt_addr_hit_o <= 1'b0;
            energy_detect_powerdown_en_o <= 1'b0;
            line_energy_present_o <= 1'b1;
            op_mode_o <= `PMX_MODE_RST;
            phy_address_field_o <= `PMX_PHY_ADDRESS_FIELD_RST;
            speed100_o <= 1'b0;
            full_duplex_o <= 1'b0;
            // reset mode is all-capable, so autoneg and the advertisement start out matching its decode
            autoneg_en_o <= 1'b1;
            advert_abilities_o <= 4'hf;
            crs_on_tx_o <= 1'b0;
            crossover_auto_en_o <= 1'b0;
            pairs_swapped_o <= 1'b0;
            rx_pll_ref_lock_force_o <= 1'b0;
            tenbase_polarity_reversed_o <= 1'b0;
        end else begin
            mgmt_rvalid_o <= mgmt_rd_i & addr_match;
            mgmt_addr_hit_o <= (mgmt_rd_i | mgmt_wr_i) & addr_match;
            mgmt_rdata_o <= 16'h0000;
            if (mgmt_rd_i && addr_match) begin
                if (mgmt_reg_addr_i == `PMX_ADDR_ENERGY_CTL) begin
                    mgmt_rdata_o[`PMX_EDPD_BIT] <= edpd_r;
                    mgmt_rdata_o[`PMX_ENERGY_BIT] <= energy_r;
                end else if (mgmt_reg_addr_i == `PMX_ADDR_MODE_ADDR) begin
                    mgmt_rdata_o[`PMX_MODE_HI:`PMX_MODE_LO] <= mode_r;
                    mgmt_rdata_o[`PMX_PHY_ADDRESS_FIELD_HI:`PMX_PHY_ADDRESS_FIELD_LO] <= phy_address_field_r;
                end else if (mgmt_reg_addr_i == `PMX_ADDR_XOVER_CTL) begin
                    mgmt_rdata_o[`PMX_XOVR_OVERRIDE_BIT] <= xovr_override_r;
                    mgmt_rdata_o[`PMX_XOVR_AUTO_BIT] <= xovr_auto_r;
                    mgmt_rdata_o[`PMX_XOVR_STATE_BIT] <= xovr_state_r;
                    mgmt_rdata_o[`PMX_PLL_FORCE_BIT] <= pll_force_r;
                    mgmt_rdata_o[`PMX_POL_BIT] <= polarity_reversed_i;
                    // low nibble has no storage, so writes cannot change it
                    mgmt_rdata_o[`PMX_SCRATCH_HI:0] <= `PMX_RSVD_RD;
                end
            end

            energy_detect_powerdown_en_o <= edpd_r;
            line_energy_present_o <= energy_r;
            op_mode_o <= mode_r;
            phy_address_field_o <= phy_address_field_r;
            rx_pll_ref_lock_force_o <= pll_force_r;
            tenbase_polarity_reversed_o <= polarity_reversed_i;

            // strap rules unless override is set; state bit only matters in manual mode
            if (xovr_override_r) begin
                crossover_auto_en_o <= xovr_auto_r;
                pairs_swapped_o <= ~xovr_auto_r & xovr_state_r;
            end else begin
                crossover_auto_en_o <= crossover_auto_strap_i;
                pairs_swapped_o <= 1'b0;
            end

            // mode 110 is not expected; it falls to the all-capable default
            case (mode_r)
                `PMX_MODE_10HD: begin
                    speed100_o <= 1'b0;
                    full_duplex_o <= 1'b0;
                    autoneg_en_o <= 1'b0;
                    advert_abilities_o <= 4'h0;
                    crs_on_tx_o <= 1'b1;
                end
                `PMX_MODE_10FD: begin
                    speed100_o <= 1'b0;
                    full_duplex_o <= 1'b1;
                    autoneg_en_o <= 1'b0;
                    advert_abilities_o <= 4'h0;
                    crs_on_tx_o <= 1'b0;
                end
                `PMX_MODE_100HD: begin
                    speed100_o <= 1'b1;
                    full_duplex_o <= 1'b0;
                    autoneg_en_o <= 1'b0;
                    advert_abilities_o <= 4'h0;
                    crs_on_tx_o <= 1'b1;
                end
                `PMX_MODE_100FD: begin
                    speed100_o <= 1'b1;
                    full_duplex_o <= 1'b1;
                    autoneg_en_o <= 1'b0;
                    advert_abilities_o <= 4'h0;
                    crs_on_tx_o <= 1'b0;
                end
                `PMX_MODE_AN100HD: begin
                    speed100_o <= 1'b1;
                    full_duplex_o <= 1'b0;
                    autoneg_en_o <= 1'b1;
                    advert_abilities_o <= 4'h4;
                    crs_on_tx_o <= 1'b1;
                end
                `PMX_MODE_REPEATER: begin
                    speed100_o <= 1'b1;
                    full_duplex_o <= 1'b0;
                    autoneg_en_o <= 1'b1;
                    advert_abilities_o <= 4'h4;
                    crs_on_tx_o <= 1'b0;
                end
                default: begin
                    speed100_o <= neg_speed100_i;
                    full_duplex_o <= neg_full_duplex_i;
                    autoneg_en_o <= 1'b1;
                    advert_abilities_o <= 4'hf;
                    crs_on_tx_o <= ~neg_full_duplex_i;
                end
            endcase
        end
    end
endmodule

/* sim/pmx_regs_checker.sv */
// checker for the phy mode/crossover register block, watching its ports only
// assumes the energy window parameter is handed over by the bind
module pmx_regs_checker #(
    parameter int WINDOW_CYCLES = 16
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic soft_rst_i,
    input wire logic mgmt_rd_i,
    input wire logic mgmt_wr_i,
    input wire logic [4:0] mgmt_phy_addr_i,
    input wire logic line_energy_i,
    input wire logic [15:0] mgmt_rdata_o,
    input wire logic mgmt_rvalid_o,
    input wire logic mgmt_addr_hit_o,
    input wire logic energy_detect_powerdown_en_o,
    input wire logic line_energy_present_o,
    input wire logic [2:0] op_mode_o,
    input wire logic [4:0] phy_address_field_o,
    input wire logic autoneg_en_o,
    input wire logic [3:0] advert_abilities_o,
    input wire logic crossover_auto_en_o,
    input wire logic pairs_swapped_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int idle_cnt;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // saturates so a long idle stretch cannot wrap back into the window
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) idle_cnt <= 0;
        else if (line_energy_i) idle_cnt <= 0;
        else if (idle_cnt < WINDOW_CYCLES + 8) idle_cnt <= idle_cnt + 1;
    end
    read_answer_a: assert property (mgmt_rd_i && mgmt_phy_addr_i == phy_address_field_o
        |=> mgmt_rvalid_o && mgmt_addr_hit_o)
        else $error("read with own address got no answer");
    foreign_addr_a: assert property ((mgmt_rd_i || mgmt_wr_i) && mgmt_phy_addr_i != phy_address_field_o
        |=> !mgmt_addr_hit_o && !mgmt_rvalid_o)
        else $error("frame for another address was answered");
    idle_rdata_a: assert property (!mgmt_rvalid_o |-> mgmt_rdata_o == 16'h0000)
        else $error("read data not zero outside an answer");
    soft_edpd_a: assert property (soft_rst_i [*2] |=> !energy_detect_powerdown_en_o)
        else $error("power-down enable survived software reset");
    energy_set_a: assert property (line_energy_i |-> ##[1:2] line_energy_present_o)
        else $error("energy flag not set by line energy");
    energy_keep_a: assert property (idle_cnt > 0 && idle_cnt < WINDOW_CYCLES && $past(line_energy_present_o)
        |-> line_energy_present_o)
        else $error("energy flag dropped inside the window");
    energy_clear_a: assert property (idle_cnt >= WINDOW_CYCLES + 4 |-> !line_energy_present_o)
        else $error("energy flag kept after the idle window");
    autoneg_mode_a: assert property ($stable(op_mode_o) |-> autoneg_en_o == op_mode_o[2])
        else $error("autoneg enable does not match mode");
    advert_half_a: assert property ($stable(op_mode_o) && op_mode_o[2:1] == 2'b10
        |-> advert_abilities_o == 4'h4)
        else $error("advertisement wrong in 100 half modes");
    swap_manual_a: assert property (pairs_swapped_o |-> !crossover_auto_en_o)
        else $error("pairs swapped while auto crossover on");
endmodule

bind pmx_mode_xover_regs pmx_regs_checker #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_chk (.clock_i, .rst_b_i, .soft_rst_i,
    .mgmt_rd_i, .mgmt_wr_i, .mgmt_phy_addr_i, .line_energy_i, .mgmt_rdata_o, .mgmt_rvalid_o, .mgmt_addr_hit_o,
    .energy_detect_powerdown_en_o, .line_energy_present_o, .op_mode_o, .phy_address_field_o, .autoneg_en_o,
    .advert_abilities_o, .crossover_auto_en_o, .pairs_swapped_o);

/* sim/pmx_mgmt_master.sv */
// management master model: issues one-cycle read and write strobes at falling edges
// assumes the register block answers a read one cycle after the strobe edge
module pmx_mgmt_master (
    input wire logic clock_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output logic wr_o,
    output logic rd_o,
    output logic [4:0] phy_o,
    output logic [4:0] reg_o,
    output logic [15:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        phy_o = 5'h1f;
        reg_o = 5'h00;
        wdata_o = 16'h5a5a;
    end
    // released register-address and write-data lines show the inverse so stale values cannot pass for held ones
    task automatic write(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        @(negedge clock_i);
        phy_o = pa;
        reg_o = ra;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clock_i);
        wr_o = 1'b0;
        reg_o = ~ra;
        wdata_o = ~d;
    endtask
    task automatic read(input logic [4:0] pa, input logic [4:0] ra, output logic [15:0] d, output logic v);
        @(negedge clock_i);
        phy_o = pa;
        reg_o = ra;
        rd_o = 1'b1;
        @(negedge clock_i);
        rd_o = 1'b0;
        reg_o = ~ra;
        d = rdata_i;
        v = rvalid_i;
    endtask
endmodule

/* sim/pmx_mode_xover_regs_tb_top.sv */
// testbench for the phy mode/crossover register block
// assumes a shortened energy window; the master model issues all management traffic
module pmx_mode_xover_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WIN = 16;
    localparam logic [3:0] EXP_MODE [8] = '{4'h1, 4'h4, 4'h9, 4'hc, 4'hb, 4'ha, 4'h0, 4'hb};
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic soft_rst_i = 1'b0, line_energy_i = 1'b1, pol_i = 1'b0, strap_i = 1'b0, spd_i = 1'b1, dup_i = 1'b0;
    wire wr, rd, rvalid, hit, edpd, energy, spd, dup, an, crs, xauto, swp, pll, polo;
    wire [4:0] pa, ra, phy_address_field;
    wire [15:0] wd, rdata;
    wire [2:0] mode;
    wire [3:0] adv;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [15:0] d;
    logic v;
    always #25 clock_i = ~clock_i;
    pmx_mgmt_master m (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr), .rd_o(rd), .phy_o(pa),
        .reg_o(ra), .wdata_o(wd));
    pmx_mode_xover_regs #(.WINDOW_CYCLES(WIN)) DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .soft_rst_i(soft_rst_i),
        .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_phy_addr_i(pa), .mgmt_reg_addr_i(ra), .mgmt_wdata_i(wd),
        .line_energy_i(line_energy_i), .polarity_reversed_i(pol_i), .crossover_auto_strap_i(strap_i),
        .neg_speed100_i(spd_i), .neg_full_duplex_i(dup_i), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid),
        .mgmt_addr_hit_o(hit), .energy_detect_powerdown_en_o(edpd), .line_energy_present_o(energy),
        .op_mode_o(mode), .phy_address_field_o(phy_address_field), .speed100_o(spd), .full_duplex_o(dup), .autoneg_en_o(an),
        .advert_abilities_o(adv), .crs_on_tx_o(crs), .crossover_auto_en_o(xauto), .pairs_swapped_o(swp),
        .rx_pll_ref_lock_force_o(pll), .tenbase_polarity_reversed_o(polo));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] p, input logic [4:0] r, input logic [15:0] exp);
        m.read(p, r, d, v);
        chk({15'h0, v}, 16'h0001);
        chk(d, exp);
    endtask
    task automatic done(input string name);
        $display("test %s finished, %0d mismatches so far", name, n_mismatch);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(negedge clock_i);
        rst_b_i = 1'b1;
        rd_chk(5'h01, 5'h11, 16'h0002);
        rd_chk(5'h01, 5'h12, 16'h00e1);
        rd_chk(5'h01, 5'h1b, 16'h0000);
        done("reset");
        m.write(5'h01, 5'h11, 16'h2000);
        rd_chk(5'h01, 5'h11, 16'h2002);
        chk({15'h0, edpd}, 16'h0001);
        m.write(5'h02, 5'h11, 16'h0000);
        rd_chk(5'h01, 5'h11, 16'h2002);
        rd_chk(5'h01, 5'h05, 16'h0000);
        done("edpd");
        for (int i = 0; i < 8; i++) begin
            if (i == 6) continue;
            m.write(5'h01, 5'h12, {8'h00, i[2:0], 5'h01});
            rd_chk(5'h01, 5'h12, {8'h00, i[2:0], 5'h01});
            chk({12'h0, spd, dup, an, crs}, {12'h0, EXP_MODE[i]});
            if (i >= 4) chk({12'h0, adv}, (i == 7) ? 16'h000f : 16'h0004);
        end
        done("modes");
        m.write(5'h01, 5'h12, 16'h00e9);
        m.read(5'h01, 5'h12, d, v);
        chk({15'h0, v}, 16'h0000);
        rd_chk(5'h09, 5'h12, 16'h00e9);
        m.write(5'h09, 5'h12, 16'h00e1);
        done("address");
        pol_i = 1'b1;
        m.write(5'h01, 5'h1b, 16'ha40f);
        rd_chk(5'h01, 5'h1b, 16'ha410);
        chk({12'h0, xauto, swp, pll, polo}, 16'h0007);
        m.write(5'h01, 5'h1b, 16'hc000);
        rd_chk(5'h01, 5'h1b, 16'hc010);
        chk({14'h0, xauto, swp}, 16'h0002);
        strap_i = 1'b1;
        m.write(5'h01, 5'h1b, 16'h4000);
        rd_chk(5'h01, 5'h1b, 16'h4010);
        chk({14'h0, xauto, swp}, 16'h0002);
        strap_i = 1'b0;
        m.write(5'h01, 5'h1b, 16'h4000);
        rd_chk(5'h01, 5'h1b, 16'h4010);
        chk({15'h0, xauto}, 16'h0000);
        done("crossover");
        m.write(5'h01, 5'h12, 16'h0061);
        m.write(5'h01, 5'h11, 16'h2000);
        m.write(5'h01, 5'h1b, 16'ha400);
        @(negedge clock_i);
        soft_rst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        soft_rst_i = 1'b0;
        rd_chk(5'h01, 5'h11, 16'h0002);
        rd_chk(5'h01, 5'h12, 16'h0061);
        rd_chk(5'h01, 5'h1b, 16'h0410);
        done("soft reset");
        line_energy_i = 1'b0;
        repeat (WIN + 6) @(negedge clock_i);
        rd_chk(5'h01, 5'h11, 16'h0000);
        chk({15'h0, energy}, 16'h0000);
        line_energy_i = 1'b1;
        rd_chk(5'h01, 5'h11, 16'h0002);
        done("energy");
        // flag is low and retained fields are programmed before the hardware reset
        line_energy_i = 1'b0;
        spd_i = 1'b0;
        dup_i = 1'b1;
        repeat (WIN + 6) @(negedge clock_i);
        chk({15'h0, energy}, 16'h0000);
        rst_b_i = 1'b0;
        @(negedge clock_i);
        rst_b_i = 1'b1;
        rd_chk(5'h01, 5'h11, 16'h0002);
        rd_chk(5'h01, 5'h12, 16'h00e1);
        rd_chk(5'h01, 5'h1b, 16'h0010);
        chk({12'h0, spd, dup, an, crs}, 16'h0006);
        done("hardware reset");
        tally_and_finish;
    end
endmodule
